/* File: sio_map.svh */
// Register indices, field positions and reset values of the serial port.
// Assumes word-wide bus access; byte address is four times the index.
`ifndef SIO_MAP_SVH
`define SIO_MAP_SVH

`define SIO_CTRL_IDX    8'he7
`define SIO_DATA_IDX    8'he8
`define SIO_RATE_IDX    8'he9
`define SIO_ISTAT_IDX   8'hea
`define SIO_IMASK_IDX   8'heb

`define SIO_CTRL_RST    8'h00
`define SIO_RATE_RST    8'h00
`define SIO_DATA_RST    8'h00
`define SIO_IRQ_RST     2'h0

`define SIO_IRQ_W       2
`define SIO_IRQ_DONE    0
`define SIO_IRQ_REFUSED 1

// Fixed divide by four gives a half period of two system clocks per step
`define SIO_HALF_DIV    9'h002
`define SIO_LAST_BIT    3'h7
`define SIO_BIT_STEP    3'h1

`endif

/* File: sio_pkg.sv */
// Types shared by the serial shift port.
// Assumes nothing beyond a SystemVerilog elaborator.
package sio_pkg;

	typedef struct packed {
		logic ext_clk;
		logic lsb_first;
		logic tx_rx;
		logic edge_sel;
		logic clr_start;
		logic shift_en;
		logic int_en;
		logic pend;
	} ctrl_type;

	typedef enum logic [0:0] {
		SHIFT_IDLE = 1'b0,
		SHIFT_RUN  = 1'b1
	} shift_state_type;

endpackage

/* File: sio_rate_tick.sv */
// Half-period tick generator for the internal shift clock.
// Assumes limit_in is stable while run_in is high.
module sio_rate_tick #(
	parameter int W = 9
)(
	// Clock and reset
	input  wire logic         clk_sys_in,
	input  wire logic         rstn_in,
	input  wire logic         ce_in,
	// Control
	input  wire logic         run_in,
	input  wire logic [W-1:0] limit_in,
	// Tick
	output logic              tick_out
);

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	assign tick_out = run_in && (cnt_reg == limit_in);

	always_comb begin
		cnt_next = cnt_reg + W'(1);
		if (!run_in || tick_out) begin
			cnt_next = '0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_reg <= '0;
		end else if (ce_in) begin
			cnt_reg <= cnt_next;
		end
	end

endmodule // sio_rate_tick

/* File: sync_serial_shift_port.sv */
// Eight-bit synchronous serial shift port with a classic Wishbone slave.
// Assumes pins are synchronous to clk_sys_in and the bus is word wide.
`include "sio_map.svh"

module sync_serial_shift_port #(
	parameter int ADR_W = 10,
	parameter int DIV_W = 9
)(
	// Clock, reset, enable
	input  wire logic             clk_sys_in,
	input  wire logic             rstn_in,
	input  wire logic             ce_in,
	// Wishbone slave
	input  wire logic             wb_cyc_in,
	input  wire logic             wb_stb_in,
	input  wire logic             wb_we_in,
	input  wire logic [ADR_W-1:0] wb_adr_in,
	input  wire logic [3:0]       wb_sel_in,
	input  wire logic [31:0]      wb_dat_in,
	output logic      [31:0]      wb_dat_out,
	output logic                  wb_ack_out,
	// Serial pins
	input  wire logic             serial_clk_in,
	output logic                  serial_clk_out,
	output logic                  serial_clk_oe_out,
	input  wire logic             serial_data_in,
	output logic                  serial_data_out,
	output logic                  serial_data_oe_out,
	// Interrupt
	output logic                  irq_out
);

	sio_pkg::ctrl_type        ctrl_reg;
	sio_pkg::ctrl_type        ctrl_next;
	sio_pkg::ctrl_type        wr_ctrl;
	sio_pkg::shift_state_type state_reg;
	sio_pkg::shift_state_type state_next;
	logic [7:0]               rate_reg;
	logic [7:0]               rate_next;
	logic [7:0]               buf_reg;
	logic [7:0]               buf_next;
	logic [`SIO_IRQ_W-1:0]    stat_reg;
	logic [`SIO_IRQ_W-1:0]    stat_next;
	logic [`SIO_IRQ_W-1:0]    mask_reg;
	logic [`SIO_IRQ_W-1:0]    mask_next;
	logic [2:0]               bit_cnt_reg;
	logic [2:0]               bit_cnt_next;
	logic                     sck_reg;
	logic                     sck_next;
	logic                     so_reg;
	logic                     so_next;
	logic                     ext_prev_reg;
	logic                     ack_reg;
	logic                     ack_next;
	logic [31:0]              rdata_reg;
	logic [31:0]              rdata_next;
	logic [7:0]               idx;
	logic                     req;
	logic                     wr_fire;
	logic [DIV_W-1:0]         half_limit;
	logic                     tick;
	logic                     busy;
	logic                     int_mode;
	logic                     rise;
	logic                     fall;
	logic                     sample;
	logic                     launch;
	logic                     last_bit;
	logic                     start;
	logic                     refused;
	logic                     done;

	// Bus decode; a write lands on the edge that sees ack high
	assign idx     = wb_adr_in[9:2];
	assign req     = wb_cyc_in && wb_stb_in;
	assign wr_fire = req && wb_we_in && ack_reg && wb_sel_in[0];
	assign wr_ctrl = sio_pkg::ctrl_type'(wb_dat_in[7:0]);

	assign busy     = (state_reg == sio_pkg::SHIFT_RUN);
	assign int_mode = !ctrl_reg.ext_clk;
	assign half_limit = DIV_W'((({1'b0, rate_reg} + 9'h001)
		* `SIO_HALF_DIV) - 9'h001);

	sio_rate_tick #(
		.W          (DIV_W)
	) u_rate_tick (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.ce_in      (ce_in),
		.run_in     (busy && int_mode),
		.limit_in   (half_limit),
		.tick_out   (tick)
	);

	// Edge events from either clock source
	always_comb begin
		if (int_mode) begin
			rise = tick && !sck_reg;
			fall = tick && sck_reg;
		end else begin
			rise = serial_clk_in && !ext_prev_reg;
			fall = !serial_clk_in && ext_prev_reg;
		end
	end

	assign sample   = ctrl_reg.edge_sel ? fall : rise;
	assign launch   = ctrl_reg.edge_sel ? rise : fall;
	assign last_bit = (bit_cnt_reg == `SIO_LAST_BIT);
	assign done     = busy && sample && last_bit;
	assign start    = wr_fire && (idx == `SIO_CTRL_IDX)
		&& wr_ctrl.clr_start && wr_ctrl.shift_en;
	// Start without enable is dropped but reported
	assign refused  = wr_fire && (idx == `SIO_CTRL_IDX)
		&& wr_ctrl.clr_start && !wr_ctrl.shift_en;

	always_comb begin
		ctrl_next    = ctrl_reg;
		rate_next    = rate_reg;
		buf_next     = buf_reg;
		stat_next    = stat_reg;
		mask_next    = mask_reg;
		state_next   = state_reg;
		bit_cnt_next = bit_cnt_reg;
		sck_next     = sck_reg;
		so_next      = so_reg;
		if (wr_fire) begin
			unique case (idx)
				`SIO_CTRL_IDX: begin
					ctrl_next           = wr_ctrl;
					ctrl_next.clr_start = 1'b0;
					ctrl_next.pend      = ctrl_reg.pend & wr_ctrl.pend;
				end
				`SIO_RATE_IDX:  rate_next = wb_dat_in[7:0];
				// Loading mid-transfer would corrupt the byte in flight
				`SIO_DATA_IDX: begin
					if (!busy) begin
						buf_next = wb_dat_in[7:0];
					end
				end
				`SIO_IMASK_IDX: mask_next = wb_dat_in[`SIO_IRQ_W-1:0];
				`SIO_ISTAT_IDX: begin
					stat_next = stat_reg & ~wb_dat_in[`SIO_IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
		unique case (state_reg)
			sio_pkg::SHIFT_RUN: begin
				if (sample) begin
					buf_next = ctrl_reg.lsb_first
						? {serial_data_in, buf_reg[7:1]}
						: {buf_reg[6:0], serial_data_in};
					bit_cnt_next = bit_cnt_reg + `SIO_BIT_STEP;
					if (last_bit) begin
						state_next = sio_pkg::SHIFT_IDLE;
					end
				end
				if (launch) begin
					so_next = ctrl_reg.lsb_first ? buf_reg[0] : buf_reg[7];
				end
				if (tick) begin
					sck_next = !sck_reg;
				end
			end
			sio_pkg::SHIFT_IDLE: begin
				sck_next = !ctrl_reg.edge_sel;
			end
		endcase
		if (start) begin
			state_next   = sio_pkg::SHIFT_RUN;
			bit_cnt_next = '0;
			so_next      = wr_ctrl.lsb_first ? buf_reg[0] : buf_reg[7];
			sck_next     = !wr_ctrl.edge_sel;
		end
		if (!ctrl_next.shift_en) begin
			state_next = sio_pkg::SHIFT_IDLE;
		end
		// Hardware set wins over a clear in the same cycle
		if (done) begin
			ctrl_next.pend             = 1'b1;
			stat_next[`SIO_IRQ_DONE]   = 1'b1;
		end
		if (refused) begin
			stat_next[`SIO_IRQ_REFUSED] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_reg     <= sio_pkg::ctrl_type'(`SIO_CTRL_RST);
			rate_reg     <= `SIO_RATE_RST;
			buf_reg      <= `SIO_DATA_RST;
			stat_reg     <= `SIO_IRQ_RST;
			mask_reg     <= `SIO_IRQ_RST;
			state_reg    <= sio_pkg::SHIFT_IDLE;
			bit_cnt_reg  <= '0;
			sck_reg      <= 1'b1;
			so_reg       <= 1'b0;
			ext_prev_reg <= 1'b1;  // Idle pin level: no false edge
		end else if (ce_in) begin
			ctrl_reg     <= ctrl_next;
			rate_reg     <= rate_next;
			buf_reg      <= buf_next;
			stat_reg     <= stat_next;
			mask_reg     <= mask_next;
			state_reg    <= state_next;
			bit_cnt_reg  <= bit_cnt_next;
			sck_reg      <= sck_next;
			so_reg       <= so_next;
			ext_prev_reg <= serial_clk_in;
		end
	end

	// Bus answer: ack one cycle after the request, read data held with it
	always_comb begin
		ack_next   = req && !ack_reg;
		rdata_next = rdata_reg;
		if (req && !ack_reg) begin
			case (idx)
				`SIO_CTRL_IDX:  rdata_next = {24'h000000, ctrl_reg};
				`SIO_DATA_IDX:  rdata_next = {24'h000000, buf_reg};
				`SIO_RATE_IDX:  rdata_next = {24'h000000, rate_reg};
				`SIO_ISTAT_IDX: rdata_next = {30'h0, stat_reg};
				`SIO_IMASK_IDX: rdata_next = {30'h0, mask_reg};
				default:        rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else if (ce_in) begin
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign wb_ack_out         = ack_reg;
	assign wb_dat_out         = rdata_reg;
	assign serial_clk_out     = sck_reg;
	assign serial_clk_oe_out  = busy && int_mode;
	assign serial_data_out    = so_reg;
	assign serial_data_oe_out = ctrl_reg.tx_rx && ctrl_reg.shift_en;
	assign irq_out = (ctrl_reg.int_en && ctrl_reg.pend)
		|| ((stat_reg & mask_reg) != '0);

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);

	property p_self_clear;
		!ctrl_reg.clr_start;
	endproperty
	a_self_clear: assert property (p_self_clear)
		else $error("start bit reads back as one");

	property p_start;
		ce_in && start |=> busy && (bit_cnt_reg == 3'h0);
	endproperty
	a_start: assert property (p_start)
		else $error("start did not begin a clean transfer");

	property p_disabled;
		ce_in && !ctrl_next.shift_en |=> !busy;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("shifting while disabled");

	property p_done;
		ce_in && done |=> ctrl_reg.pend && stat_reg[`SIO_IRQ_DONE];
	endproperty
	a_done: assert property (p_done)
		else $error("finished byte did not set pending");

	property p_not_last;
		ce_in && busy && sample && !last_bit && ctrl_next.shift_en
			&& !start |=> busy;
	endproperty
	a_not_last: assert property (p_not_last)
		else $error("transfer ended before eighth bit");

	property p_irq_gate;
		!ctrl_reg.int_en && ((stat_reg & mask_reg) == 2'h0) |-> !irq_out;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("masked pending reached interrupt line");

	property p_pend_clear;
		ce_in && wr_fire && (idx == `SIO_CTRL_IDX) && !wb_dat_in[0] && !done
			|=> !ctrl_reg.pend;
	endproperty
	a_pend_clear: assert property (p_pend_clear)
		else $error("writing zero did not clear pending");

	property p_first_bit;
		ce_in && start && !wr_ctrl.lsb_first
			|=> serial_data_out == $past(buf_reg[7]);
	endproperty
	a_first_bit: assert property (p_first_bit)
		else $error("first bit is not the top bit");

	property p_clk_drive;
		busy && !ctrl_reg.ext_clk |-> serial_clk_oe_out;
	endproperty
	a_clk_drive: assert property (p_clk_drive)
		else $error("internal clock not driven during transfer");

	property p_ext_hands_off;
		ctrl_reg.ext_clk || !busy |-> !serial_clk_oe_out;
	endproperty
	a_ext_hands_off: assert property (p_ext_hands_off)
		else $error("clock pin driven in external mode");

	property p_rate_toggle;
		ce_in && tick && busy && !start && ctrl_next.shift_en
			|=> serial_clk_out != $past(serial_clk_out);
	endproperty
	a_rate_toggle: assert property (p_rate_toggle)
		else $error("tick did not toggle the shift clock");

	property p_idle_level;
		ce_in && !busy && !start ##1 ce_in && !busy && $stable(ctrl_reg)
			|-> serial_clk_out == !ctrl_reg.edge_sel;
	endproperty
	a_idle_level: assert property (p_idle_level)
		else $error("idle clock level wrong");

	c_done_msb: cover property (done && !ctrl_reg.lsb_first);
	c_done_lsb: cover property (done && ctrl_reg.lsb_first);
	c_done_ext: cover property (done && ctrl_reg.ext_clk);
	c_refused:  cover property (refused);

endmodule // sync_serial_shift_port

/* File: sio_peer_model.sv */
// Behavioural far-side serial device for the shift port bench.
// Assumes a resolved shift clock, synchronous to clk_sys_in.
module sio_peer_model (
	// Clocks
	input  wire logic       clk_sys_in,
	input  wire logic       sck_in,
	// Setup
	input  wire logic       edge_sel_in,
	input  wire logic       lsb_first_in,
	input  wire logic       load_in,
	input  wire logic [7:0] tx_byte_in,
	// Data
	input  wire logic       din_in,
	output logic            dout_out,
	output logic [7:0]      rx_byte_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       sck_q;
	logic [3:0] cnt;
	logic       rise;
	logic       fall;
	assign rise = sck_in & ~sck_q;
	assign fall = ~sck_in & sck_q;
	initial begin
		cnt = 4'h8;
		dout_out = 1'b0;
		sck_q = 1'b1;
	end
	always @(posedge clk_sys_in) begin
		sck_q <= sck_in;
		if (load_in) begin
			cnt <= 4'h0;
			dout_out <= lsb_first_in ? tx_byte_in[0] : tx_byte_in[7];
		end else if (cnt == 4'h8) begin
			// Released line toggles so a stale bit never looks valid
			dout_out <= ~dout_out;
		end else if (edge_sel_in ? rise : fall) begin
			dout_out <= lsb_first_in ? tx_byte_in[cnt[2:0]]
				: tx_byte_in[3'h7 - cnt[2:0]];
		end else if (edge_sel_in ? fall : rise) begin
			cnt <= cnt + 4'h1;
			rx_byte_out <= lsb_first_in ? {din_in, rx_byte_out[7:1]}
				: {rx_byte_out[6:0], din_in};
		end
	end
endmodule // sio_peer_model

/* File: tb_top.sv */
// Self-checking bench for the serial shift port and its far-side peer.
// Assumes sio_map.svh, sio_pkg and the design are compiled first.
`include "sio_map.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
	miscompares++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_in, rstn_in, wb_cyc, wb_stb, wb_we, wb_ack;
	logic        ext_clk, peer_load, edge_cfg, lsb_cfg, sck, sck_out;
	logic        sck_oe, sdo, sdo_oe, sdi, irq;
	logic [9:0]  wb_adr;
	logic [31:0] wb_wdat, wb_rdat, rd;
	logic [7:0]  peer_tx, peer_rx;
	int          miscompares = 0;
	int          comparisons = 0;
	int          cycles = 0;

	assign sck = sck_oe ? sck_out : ext_clk;

	sync_serial_shift_port u_dut (.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in), .ce_in(1'b1), .wb_cyc_in(wb_cyc),
		.wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
		.wb_sel_in(4'hf), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat),
		.wb_ack_out(wb_ack), .serial_clk_in(sck), .serial_clk_out(sck_out),
		.serial_clk_oe_out(sck_oe), .serial_data_in(sdi),
		.serial_data_out(sdo), .serial_data_oe_out(sdo_oe), .irq_out(irq));

	sio_peer_model u_peer (.clk_sys_in(clk_sys_in), .sck_in(sck),
		.edge_sel_in(edge_cfg), .lsb_first_in(lsb_cfg),
		.load_in(peer_load), .tx_byte_in(peer_tx), .din_in(sdo),
		.dout_out(sdi), .rx_byte_out(peer_rx));

	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	task automatic end_of_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test;
		end
	end

	task automatic wb(input logic we, input logic [7:0] idx,
		input logic [7:0] wd);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'b00};
		wb_wdat <= {24'h000000, wd};
		@(posedge clk_sys_in);
		// No local limit: only the bench timeout ends a hung cycle
		while (wb_ack !== 1'b1) begin
			@(posedge clk_sys_in);
		end
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
		wb(1'b0, idx, 8'h00);
		`CHK(rd, exp)
	endtask

	task automatic t_reset;
		rdchk(`SIO_CTRL_IDX, 32'h0);
		rdchk(`SIO_RATE_IDX, 32'h0);
		rdchk(`SIO_ISTAT_IDX, 32'h0);
		rdchk(8'h10, 32'h0);
		`CHK(irq, 1'b0)
		$display("test reset done");
	endtask

	task automatic t_no_enable;
		logic seen;
		seen = 1'b0;
		wb(1'b1, `SIO_CTRL_IDX, 8'h0a);
		repeat (40) begin
			@(posedge clk_sys_in);
			seen = seen | sck_oe;
		end
		`CHK(seen, 1'b0)
		rdchk(`SIO_CTRL_IDX, 32'h02);
		rdchk(`SIO_ISTAT_IDX, 32'h2);
		wb(1'b1, `SIO_IMASK_IDX, 8'h02);
		`CHK(irq, 1'b1)
		wb(1'b1, `SIO_ISTAT_IDX, 8'h02);
		`CHK(irq, 1'b0)
		wb(1'b1, `SIO_IMASK_IDX, 8'h00);
		$display("test start without enable done");
	endtask

	task automatic xfer(input logic [7:0] cfg, input logic [7:0] rate,
		input logic [7:0] tx, input logic [7:0] ptx);
		int n;
		edge_cfg <= cfg[4];
		lsb_cfg <= cfg[6];
		ext_clk <= ~cfg[4];
		peer_tx <= ptx;
		peer_load <= 1'b1;
		@(posedge clk_sys_in);
		peer_load <= 1'b0;
		wb(1'b1, `SIO_RATE_IDX, rate);
		wb(1'b1, `SIO_DATA_IDX, tx);
		wb(1'b1, `SIO_CTRL_IDX, cfg | 8'h0e);
		n = 0;
		while (irq !== 1'b1) begin
			// External clock: 16 edges, three cycles apart
			if (cfg[7] && n < 48 && n % 3 == 0)
				ext_clk <= ~ext_clk;
			if (n == 10)
				`CHK(sck_oe, ~cfg[7])
			@(posedge clk_sys_in);
			n++;
		end
		if (!cfg[7])
			`CHK(n >= 32 * (rate + 1) - 2 && n <= 32 * (rate + 1) + 2, 1'b1)
		`CHK(sdo_oe, cfg[5])
		rdchk(`SIO_DATA_IDX, {24'h000000, ptx});
		if (cfg[5])
			`CHK(peer_rx, tx)
		rdchk(`SIO_CTRL_IDX, {24'h000000, cfg | 8'h07});
		wb(1'b1, `SIO_CTRL_IDX, cfg | 8'h07);
		`CHK(irq, 1'b1)
		wb(1'b1, `SIO_CTRL_IDX, cfg | 8'h05);
		`CHK(irq, 1'b0)
		wb(1'b1, `SIO_CTRL_IDX, cfg | 8'h06);
		rdchk(`SIO_CTRL_IDX, {24'h000000, cfg | 8'h06});
		rdchk(`SIO_ISTAT_IDX, 32'h1);
		wb(1'b1, `SIO_ISTAT_IDX, 8'h01);
		rdchk(`SIO_ISTAT_IDX, 32'h0);
		$display("test transfer cfg %h rate %h done", cfg, rate);
	endtask

	initial begin
		rstn_in = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 10'h000;
		wb_wdat = 32'h0;
		ext_clk = 1'b1;
		peer_load = 1'b0;
		edge_cfg = 1'b0;
		lsb_cfg = 1'b0;
		peer_tx = 8'h00;
		repeat (20) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		@(posedge clk_sys_in);
		t_reset;
		t_no_enable;
		for (int i = 0; i < 8; i++)
			xfer({1'b0, i[2:0], 4'h0}, i[0] ? 8'h02 : 8'h00,
				8'h96 + 8'(i), 8'h3c + 8'(i));
		xfer(8'ha0, 8'h00, 8'hc3, 8'h5a);
		xfer(8'hf0, 8'h00, 8'h81, 8'h17);
		end_of_test;
	end
endmodule // tb_top
